// ===== core/itm_pkg.sv
// Package holding register map, field layout and reset values of the interval timer.
package itm_pkg;

	// ====================================================================
	// Register map
	localparam logic [3:0] ITM_ADDR_COUNT = 4'h0;
	localparam logic [3:0] ITM_ADDR_SCALE = 4'h1;
	localparam logic [3:0] ITM_ADDR_PERIOD = 4'h2;
	localparam logic [3:0] ITM_ADDR_CTRL = 4'h3;
	localparam logic [3:0] ITM_ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ITM_ADDR_IRQ_CLR = 4'h5;
	localparam logic [3:0] ITM_ADDR_IRQ_EN = 4'h6;

	// ====================================================================
	// Widths, fields and reset values
	localparam int ITM_ADDR_W = 4;
	localparam int ITM_DATA_W = 16;
	localparam int ITM_COUNT_W = 16;
	localparam int ITM_SCALE_W = 8;
	localparam int ITM_CTRL_RUN_BIT = 0;
	localparam int ITM_IRQ_ZERO_BIT = 0;
	localparam logic [15:0] ITM_COUNT_RST = 16'h0000;
	localparam logic [7:0] ITM_SCALE_RST = 8'h00;
	localparam logic [15:0] ITM_PERIOD_RST = 16'h0000;
	localparam logic ITM_RUN_RST = 1'b0;

	typedef struct packed {
		logic [ITM_ADDR_W-1:0] addr;
		logic [ITM_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} itm_bus_req_s;

endpackage

// ===== core/itm_interval_timer.sv
// Interval timer: prescaled 16-bit down-counter with auto reload and interrupt.
`timescale 1ns/10ps
module itm_interval_timer
	import itm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire itm_pkg::itm_bus_req_s bus_req,
	output logic [itm_pkg::ITM_DATA_W-1:0] bus_rdata,
	output logic irq
);
	import itm_pkg::*;

	// ====================================================================
	// State
	logic [ITM_COUNT_W-1:0] count_reg, count_next;
	logic [ITM_SCALE_W-1:0] scale_reg, scale_next;
	logic [ITM_SCALE_W-1:0] pre_reg, pre_next;
	logic [ITM_COUNT_W-1:0] period_reg, period_next;
	logic run_reg, run_next;
	logic stat_reg, stat_next;
	logic en_reg, en_next;
	logic [ITM_DATA_W-1:0] rdata_reg, rdata_next;
	logic tick;
	logic zero_hit;
	logic wr_count, wr_scale, wr_period;

	// ====================================================================
	// Counting logic
	always_comb begin
		wr_count = bus_req.wr && (bus_req.addr == ITM_ADDR_COUNT);
		wr_scale = bus_req.wr && (bus_req.addr == ITM_ADDR_SCALE);
		wr_period = bus_req.wr && (bus_req.addr == ITM_ADDR_PERIOD);
		tick = run_reg && (pre_reg == '0);
		zero_hit = tick && (count_reg == 16'h0001);
		pre_next = pre_reg;
		count_next = count_reg;
		if (run_reg) begin
			if (tick) begin
				pre_next = scale_reg;
			end else begin
				pre_next = pre_reg - 8'h01;
			end
		end
		// A software write to the count wins over a same-cycle decrement so the
		// loaded value is never lost.
		if (wr_count) begin
			count_next = bus_req.wdata;
		end else if (tick) begin
			if (zero_hit || count_reg == '0) begin
				count_next = period_reg;
			end else begin
				count_next = count_reg - 16'h0001;
			end
		end
		if (wr_scale) begin
			pre_next = bus_req.wdata[ITM_SCALE_W-1:0];
		end
	end

	// ====================================================================
	// Register file and interrupt
	always_comb begin
		scale_next = wr_scale ? bus_req.wdata[ITM_SCALE_W-1:0] : scale_reg;
		period_next = wr_period ? bus_req.wdata : period_reg;
		run_next = run_reg;
		en_next = en_reg;
		stat_next = stat_reg;
		if (bus_req.wr && bus_req.addr == ITM_ADDR_CTRL) begin
			run_next = bus_req.wdata[ITM_CTRL_RUN_BIT];
		end
		if (bus_req.wr && bus_req.addr == ITM_ADDR_IRQ_EN) begin
			en_next = bus_req.wdata[ITM_IRQ_ZERO_BIT];
		end
		if (bus_req.wr && bus_req.addr == ITM_ADDR_IRQ_CLR && bus_req.wdata[ITM_IRQ_ZERO_BIT]) begin
			stat_next = 1'b0;
		end
		// Set after clear so a zero crossing in the clear cycle is kept.
		if (zero_hit) begin
			stat_next = 1'b1;
		end
		rdata_next = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				ITM_ADDR_COUNT: rdata_next = count_reg;
				ITM_ADDR_SCALE: rdata_next = {8'h00, scale_reg};
				ITM_ADDR_PERIOD: rdata_next = period_reg;
				ITM_ADDR_CTRL: rdata_next = {15'h0000, run_reg};
				ITM_ADDR_IRQ_STAT: rdata_next = {15'h0000, stat_reg};
				ITM_ADDR_IRQ_EN: rdata_next = {15'h0000, en_reg};
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_reg <= ITM_COUNT_RST;
			scale_reg <= ITM_SCALE_RST;
			pre_reg <= ITM_SCALE_RST;
			period_reg <= ITM_PERIOD_RST;
			run_reg <= ITM_RUN_RST;
			stat_reg <= 1'b0;
			en_reg <= 1'b0;
			rdata_reg <= '0;
		end else if (clk_en) begin
			count_reg <= count_next;
			scale_reg <= scale_next;
			pre_reg <= pre_next;
			period_reg <= period_next;
			run_reg <= run_next;
			stat_reg <= stat_next;
			en_reg <= en_next;
			rdata_reg <= rdata_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign irq = stat_reg && en_reg;

	// ====================================================================
	// Checks
	sequence s_tick_at_one;
		tick && count_reg == 16'h0001 && !wr_count;
	endsequence

	a_zero_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_tick_at_one and clk_en) |=> (count_reg == $past(period_reg)))
		else $error("count did not reload from period at zero");

	a_zero_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_tick_at_one and clk_en) |=> stat_reg)
		else $error("zero crossing did not set status");

	a_no_idle_dec: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!tick && !wr_count) |=> $stable(count_reg))
		else $error("count changed without a prescale tick");

	a_step_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && tick && !wr_count && count_reg > 16'h0001) |=> (count_reg == $past(count_reg) - 16'h0001))
		else $error("count did not step by one");

	a_pre_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && tick && !wr_scale) |=> (pre_reg == scale_reg))
		else $error("prescale counter did not reload");

	a_scale_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && run_reg && scale_reg == 8'h00 && pre_reg == 8'h00 && !wr_scale && !bus_req.wr) |=> tick)
		else $error("zero prescale did not tick every cycle");

	// The level must survive any cycle without a bus write, since only software may drop it.
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && stat_reg && en_reg && !bus_req.wr) |=> irq)
		else $error("interrupt level dropped without software action");

	a_pre_countdown: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && run_reg && pre_reg != 8'h00 && !wr_scale) |=> (pre_reg == $past(pre_reg) - 8'h01))
		else $error("prescale counter did not count down");

	// ====================================================================
	// Check sequences
	sequence s_run_enabled;
		clk_en && run_reg;
	endsequence

	sequence s_tick_at_zero;
		tick && count_reg == 16'h0000 && !wr_count;
	endsequence

	sequence s_read_at(logic [ITM_ADDR_W-1:0] a);
		clk_en && bus_req.rd && bus_req.addr == a;
	endsequence

	sequence s_write_at(logic [ITM_ADDR_W-1:0] a);
		clk_en && bus_req.wr && bus_req.addr == a;
	endsequence

	sequence s_frozen;
		!clk_en;
	endsequence

	sequence s_zero_cross;
		clk_en && zero_hit;
	endsequence

	// ====================================================================
	// Checks on an empty counter
	// A counter that software loaded with zero still reloads, but it has not
	// crossed from one to zero, so no request may be raised for it.
	a_empty_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_tick_at_zero and s_run_enabled) |=> (count_reg == $past(period_reg)))
		else $error("empty count did not reload from period");

	a_empty_no_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_tick_at_zero and s_run_enabled and !stat_reg) |=> !stat_reg)
		else $error("empty count raised a request");

	// ====================================================================
	// Checks on the interrupt status
	a_no_false_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !zero_hit && !stat_reg) |=> !stat_reg)
		else $error("status set without a zero crossing");

	a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_zero_cross |=> stat_reg)
		else $error("zero crossing lost against a clear or count write");

	a_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_zero_cross and (en_reg && !(bus_req.wr && bus_req.addr == ITM_ADDR_IRQ_EN))) |=> irq)
		else $error("enabled zero crossing did not raise the interrupt");

	a_clear_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_write_at(ITM_ADDR_IRQ_CLR) and (bus_req.wdata[ITM_IRQ_ZERO_BIT] && !zero_hit)) |=> !stat_reg)
		else $error("status clear had no effect");

	a_read_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_at(ITM_ADDR_IRQ_STAT) |=> (bus_rdata == {15'h0000, $past(stat_reg)}))
		else $error("status read returned a wrong value");

	// ====================================================================
	// Checks on the clock enable
	// A frozen cycle must look to software as if it never happened, so every
	// piece of timer state and the read data hold still.
	a_freeze_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_frozen |=> $stable(count_reg))
		else $error("count moved while frozen");

	a_freeze_pre: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_frozen |=> $stable(pre_reg))
		else $error("prescale counter moved while frozen");

	a_freeze_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_frozen |=> $stable(stat_reg))
		else $error("status moved while frozen");

	a_freeze_rdata: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_frozen |=> $stable(bus_rdata))
		else $error("read data moved while frozen");

	// ====================================================================
	// Checks on a stopped timer
	a_stopped_pre: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !run_reg && !wr_scale) |=> $stable(pre_reg))
		else $error("prescale counter moved while stopped");

	a_stopped_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!run_reg && !wr_count) |=> $stable(count_reg))
		else $error("count moved while stopped");

	// The prescale counter only counts down or loads the prescale value, so it
	// can never stand above it.
	a_pre_bounded: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pre_reg <= scale_reg)
		else $error("prescale counter above prescale value");

	// ====================================================================
	// Checks on register access
	a_write_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_at(ITM_ADDR_COUNT) |=> (count_reg == $past(bus_req.wdata)))
		else $error("count write lost");

	a_write_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_at(ITM_ADDR_SCALE) |=> (scale_reg == $past(bus_req.wdata[ITM_SCALE_W-1:0]) && pre_reg == scale_reg))
		else $error("prescale write did not load value and counter");

	a_write_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_at(ITM_ADDR_PERIOD) |=> (period_reg == $past(bus_req.wdata)))
		else $error("period write lost");

	a_write_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_at(ITM_ADDR_CTRL) |=> (run_reg == $past(bus_req.wdata[ITM_CTRL_RUN_BIT])))
		else $error("run bit write lost");

	a_read_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_at(ITM_ADDR_COUNT) |=> (bus_rdata == $past(count_reg)))
		else $error("count read returned a wrong value");

	a_read_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_at(ITM_ADDR_SCALE) |=> (bus_rdata == {8'h00, $past(scale_reg)}))
		else $error("prescale read returned a wrong value");

	a_read_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_at(ITM_ADDR_PERIOD) |=> (bus_rdata == $past(period_reg)))
		else $error("period read returned a wrong value");

endmodule

// ===== dv/tb_top.sv
// Testbench for the interval timer: registers, reload interval and masked interrupt.
`timescale 1ns/10ps
module tb_top;
	import itm_pkg::*;
	logic ref_clk;
	logic rst_n;
	logic clk_en;
	itm_bus_req_s bus_req;
	logic [ITM_DATA_W-1:0] bus_rdata;
	logic irq;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] v;
	int t1;
	int t2;

	itm_interval_timer u_itm_interval_timer (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;

	// ====================================================================
	// Bus and compare tasks
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	// Polls irq once per cycle; gives up after a bound so a dead timer cannot hang.
	task automatic wait_irq(output int t);
		t = -1;
		for (int i = 0; i < 2000 && t < 0; i++) begin
			@(posedge ref_clk);
			#1;
			if (irq === 1'b1) t = cyc;
		end
		if (t < 0) chk("irq", 16'h0001, 16'h0000);
	endtask

	// ====================================================================
	// Scenarios
	task automatic test_reset;
		for (int a = 0; a < 16; a++) begin
			if (a != 5) begin
				rd(a[3:0], v);
				chk("reset read", 16'h0000, v);
			end
		end
		chk("reset irq", 16'h0000, {15'h0000, irq});
	endtask
	task automatic test_regs;
		wr(ITM_ADDR_SCALE, 16'hFFA5);
		wr(ITM_ADDR_PERIOD, 16'hBEEF);
		rd(ITM_ADDR_SCALE, v);
		chk("scale", 16'h00A5, v);
		rd(ITM_ADDR_PERIOD, v);
		chk("period", 16'hBEEF, v);
	endtask
	task automatic test_period(input int s, input int p);
		wr(ITM_ADDR_CTRL, 16'h0000);
		wr(ITM_ADDR_SCALE, s[15:0]);
		wr(ITM_ADDR_PERIOD, p[15:0]);
		wr(ITM_ADDR_COUNT, p[15:0]);
		wr(ITM_ADDR_IRQ_EN, 16'h0001);
		wr(ITM_ADDR_IRQ_CLR, 16'h0001);
		wr(ITM_ADDR_CTRL, 16'h0001);
		wait_irq(t1);
		rd(ITM_ADDR_COUNT, v);
		chk("reloaded count", p[15:0] - 16'(s == 0), v);
		wr(ITM_ADDR_IRQ_CLR, 16'h0001);
		wait_irq(t2);
		chk("irq interval", 16'(p * (s + 1)), 16'(t2 - t1));
	endtask
	task automatic test_mask;
		wr(ITM_ADDR_IRQ_EN, 16'h0000);
		repeat (30) @(posedge ref_clk);
		#1 chk("masked irq", 16'h0000, {15'h0000, irq});
		rd(ITM_ADDR_IRQ_STAT, v);
		chk("status", 16'h0001, v);
		wr(ITM_ADDR_CTRL, 16'h0000);
		wr(ITM_ADDR_IRQ_CLR, 16'h0001);
		rd(ITM_ADDR_IRQ_STAT, v);
		chk("cleared status", 16'h0000, v);
	endtask
	// Two running cycles before the freeze and one after it, twenty frozen between.
	task automatic test_freeze;
		logic [15:0] v0;
		wr(ITM_ADDR_CTRL, 16'h0000);
		wr(ITM_ADDR_SCALE, 16'h0000);
		wr(ITM_ADDR_PERIOD, 16'h0100);
		wr(ITM_ADDR_COUNT, 16'h0100);
		wr(ITM_ADDR_CTRL, 16'h0001);
		rd(ITM_ADDR_COUNT, v0);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (20) @(posedge ref_clk);
		clk_en <= 1'b1;
		rd(ITM_ADDR_COUNT, v);
		chk("frozen count", v0 - 16'h0003, v);
		wr(ITM_ADDR_CTRL, 16'h0000);
	endtask

	// ====================================================================
	// Sequence, watchdog and verdict
	task automatic test_done;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		clk_en = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		test_reset;
		test_regs;
		test_period(0, 5);
		test_period(3, 5);
		test_period(255, 2);
		test_mask;
		test_freeze;
		test_done;
	end
	initial begin
		#(50 * 10000);
		error_cnt++;
		test_done;
	end
endmodule
